// ### src/fcr_defs.vh
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH
`define FCR_REG_W 10
`define FCR_BIT_PHASE_A_HIGH_OVERVOLTAGE 0
`define FCR_BIT_PHASE_B_HIGH_OVERVOLTAGE 1
`define FCR_BIT_PHASE_C_HIGH_OVERVOLTAGE 2
`define FCR_BIT_PHASE_A_LOW_OVERVOLTAGE 3
`define FCR_BIT_PHASE_B_LOW_OVERVOLTAGE 4
`define FCR_BIT_PHASE_C_LOW_OVERVOLTAGE 5
`define FCR_BIT_REGULATOR_UNDERVOLTAGE 6
`define FCR_BIT_BOOT_UNDERVOLTAGE_A 7
`define FCR_BIT_BOOT_UNDERVOLTAGE_B 8
`define FCR_BIT_BOOT_UNDERVOLTAGE_C 9
`define FCR_REG_RESET 10'h000
`define FCR_CLK_MHZ 50
`define FCR_MON_DELAY_NS 600
`define FCR_MON_DELAY_CYC ((`FCR_MON_DELAY_NS * `FCR_CLK_MHZ + 999) / 1000)
`endif

// ### src/fcr_fault_capture_serial_readout.v
`timescale 1ns/1ps
`include "fcr_defs.vh"

// ----------------------------------------------
// fifo of captured snapshots
// ----------------------------------------------
module fcr_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   // handshake flags
   assign in_ready_out = (cnt_q != DEPTH[AW:0]);
   assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign out_data_out = mem_q[rp_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   // pointers and fill count
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // write port
   always @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end
endmodule

// ----------------------------------------------
// fault capture with serial readout
// ----------------------------------------------
module fcr_fault_capture_serial_readout #(
   parameter DEPTH = 16,
   parameter DEAD_CYC = 25,
   parameter MON_CYC = `FCR_MON_DELAY_CYC
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire [5:0] fet_on_in,
   input wire [5:0] vds_over_in,
   input wire regulator_uv_in,
   input wire [2:0] boot_uv_in,
   input wire logic_uv_in,
   input wire overtemp_in,
   input wire short_latch_enable_in,
   input wire fault_flag_data_in,
   output wire fault_flag_data_out,
   output wire fault_flag_data_oe_n_out,
   input wire fault_flag_clock_in,
   output wire fault_flag_clock_out,
   output wire fault_flag_clock_oe_n_out,
   output wire outputs_disable_out,
   output wire [`FCR_REG_W-1:0] fault_capture_out,
   output wire snap_valid_out,
   input wire snap_ready_in,
   output wire [`FCR_REG_W-1:0] snap_data_out
);
   localparam BLANK_CYC = DEAD_CYC + MON_CYC;
   localparam BW = 8;
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_SHIFT = 2'h2;

   reg [2:0] sync_q;
   reg [1:0] st_q;
   reg [3:0] idx_q;
   reg [`FCR_REG_W-1:0] capture_q;
   reg [2:0] boot_state_q;
   reg [5:0] short_state_q;
   reg [5:0] fet_prev_q;
   reg [BW*6-1:0] blank_q;
   reg data_low_q;
   reg clock_low_q;
   reg [4:0] async_s1_q;
   reg [4:0] async_s2_q;
   wire clk_sync;
   wire clk_fall;
   wire clk_rise;
   wire [5:0] vds_valid;
   wire short_now;
   wire uv_now;
   wire fault_now;
   wire done_edge;
   wire fifo_ready;
   wire reg_uv;
   wire lgc_uv;
   wire [2:0] bt_uv;
   wire ovt;

   // two-stage synchroniser for boot, logic and overtemp monitor levels
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         async_s1_q <= 5'h00;
         async_s2_q <= 5'h00;
      end else begin
         async_s1_q <= {overtemp_in, logic_uv_in, boot_uv_in};
         async_s2_q <= async_s1_q;
      end
   end
   // monitor levels, synchronised except regulator_uv_in
   assign bt_uv = async_s2_q[2:0];
   assign lgc_uv = async_s2_q[3];
   assign ovt = async_s2_q[4];
   assign reg_uv = regulator_uv_in;

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         // pin is pulled low in reset, so no false edge follows
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], fault_flag_clock_in};
      end
   end
   assign clk_sync = sync_q[1];
   assign clk_fall = sync_q[2] & ~sync_q[1];
   assign clk_rise = ~sync_q[2] & sync_q[1];

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_blank
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               blank_q[g*BW +: BW] <= {BW{1'b0}};
            end else if (!fet_on_in[g]) begin
               blank_q[g*BW +: BW] <= {BW{1'b0}};
            end else if (!fet_prev_q[g]) begin
               blank_q[g*BW +: BW] <= BLANK_CYC[BW-1:0];
            end else if (blank_q[g*BW +: BW] != {BW{1'b0}}) begin
               blank_q[g*BW +: BW] <= blank_q[g*BW +: BW] - 1'b1;
            end
         end
         assign vds_valid[g] = fet_on_in[g] & fet_prev_q[g] & vds_over_in[g]
            & (blank_q[g*BW +: BW] == {BW{1'b0}});
      end
   endgenerate

   // previous on levels mark each turn-on
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         fet_prev_q <= 6'h00;
      end else begin
         fet_prev_q <= fet_on_in;
      end
   end

   // readout finished on the falling edge after the last bit
   assign done_edge = (st_q == ST_SHIFT) && clk_fall && (idx_q == `FCR_REG_W - 1);

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         capture_q <= `FCR_REG_RESET;
         boot_state_q <= 3'h0;
         short_state_q <= 6'h00;
      end else if (lgc_uv) begin
         capture_q <= `FCR_REG_RESET;
         boot_state_q <= 3'h0;
         short_state_q <= 6'h00;
      end else if (done_edge) begin
         // clear after readout, new events still kept
         capture_q <= {bt_uv, reg_uv, vds_valid};
         boot_state_q <= bt_uv;
         short_state_q <= vds_valid & {6{short_latch_enable_in}};
      end else begin
         capture_q <= capture_q | {bt_uv, reg_uv, vds_valid};
         boot_state_q <= boot_state_q | bt_uv;
         short_state_q <= short_state_q | (vds_valid & {6{short_latch_enable_in}});
      end
   end

   // present fault states, unlatched ones follow inputs
   assign short_now = (|short_state_q) | (|vds_valid);
   assign uv_now = lgc_uv | reg_uv | (|boot_state_q);
   assign fault_now = short_now | uv_now;

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= ST_IDLE;
         idx_q <= 4'h0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               idx_q <= 4'h0;
               if (fault_now && !lgc_uv && clk_sync) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!fault_now || lgc_uv) begin
                  st_q <= ST_IDLE;
               end else if (clk_fall) begin
                  st_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (lgc_uv) begin
                  st_q <= ST_IDLE;
               end else if (clk_fall) begin
                  if (idx_q == `FCR_REG_W - 1) begin
                     st_q <= ST_IDLE;
                     idx_q <= 4'h0;
                  end else begin
                     idx_q <= idx_q + 1'b1;
                  end
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         data_low_q <= 1'b1;
         clock_low_q <= 1'b1;
      end else if (lgc_uv) begin
         data_low_q <= 1'b0;
         clock_low_q <= 1'b0;
      end else if (done_edge) begin
         data_low_q <= 1'b1;
         clock_low_q <= 1'b1;
      end else if (st_q == ST_SHIFT) begin
         data_low_q <= ~capture_q[idx_q];
         clock_low_q <= 1'b0;
      end else if (fault_now) begin
         data_low_q <= ~uv_now;
         clock_low_q <= 1'b0;
      end else begin
         data_low_q <= 1'b1;
         clock_low_q <= 1'b1;
      end
   end

   // open-drain pins only ever pull low
   assign fault_flag_data_out = 1'b0;
   assign fault_flag_data_oe_n_out = ~data_low_q;
   assign fault_flag_clock_out = 1'b0;
   assign fault_flag_clock_oe_n_out = ~clock_low_q;
   assign outputs_disable_out = fault_now & ~(short_now & ~uv_now & ~(|short_state_q));
   assign fault_capture_out = capture_q;

   // snapshot of each completed readout while the fifo has room
   fcr_fifo #(
      .WIDTH(`FCR_REG_W),
      .DEPTH(DEPTH),
      .AW(4)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(done_edge),
      .in_ready_out(fifo_ready),
      .in_data_in(capture_q),
      .out_valid_out(snap_valid_out),
      .out_ready_in(snap_ready_in),
      .out_data_out(snap_data_out)
   );
endmodule

// ### tb/fcr_chk.sv
`timescale 1ns/1ps
`include "fcr_defs.vh"
// ------------------------------
// port checker
// ------------------------------
module fcr_chk (
   input wire clk_in,
   input wire rst_n_in,
   input wire [5:0] fet_on_in,
   input wire regulator_uv_in,
   input wire [2:0] boot_uv_in,
   input wire logic_uv_in,
   input wire fault_flag_data_out,
   input wire fault_flag_data_oe_n_out,
   input wire fault_flag_clock_out,
   input wire fault_flag_clock_oe_n_out,
   input wire [`FCR_REG_W-1:0] fault_capture_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // pins only ever pulled low
   drive_low_a: assert property (!fault_flag_data_out && !fault_flag_clock_out)
      else $error("flag drive level not low");
   reset_clear_a: assert property ($rose(rst_n_in) |-> fault_capture_out == 10'h000 &&
      !fault_flag_data_oe_n_out && !fault_flag_clock_oe_n_out) else $error("reset not clean");
   uv_release_a: assert property (logic_uv_in [*6] |-> fault_capture_out == 10'h000 &&
      fault_flag_data_oe_n_out && fault_flag_clock_oe_n_out) else $error("logic uv wrong");
   flag_pair_a: assert property (!fault_flag_clock_oe_n_out |-> !fault_flag_data_oe_n_out)
      else $error("data flag released without clock flag");
   reg_latch_a: assert property (!logic_uv_in [*4] ##0 regulator_uv_in |->
      ##2 fault_capture_out[6]) else $error("regulator bit not set");
   boot_pos_a: assert property ((boot_uv_in[2] && !logic_uv_in) [*5] |->
      ##1 fault_capture_out[9]) else $error("phase c boot bit not set");
   blank_hold_a: assert property (($rose(fet_on_in[1]) && !fault_capture_out[1]) ##1
      fet_on_in[1] [*8] |=> !fault_capture_out[1]) else $error("short seen in blank");
   off_ignore_a: assert property ((!fet_on_in[3]) [*8] ##0 !fault_capture_out[3] |=>
      !fault_capture_out[3]) else $error("short seen while off");
endmodule

bind fcr_fault_capture_serial_readout fcr_chk fcr_chk_inst (.*);

// ### tb/fcr_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------
// controller reading the flags
// ------------------------------
module fcr_ctrl_model (
   input wire clk_in,
   input wire data_pin_in,
   output logic clock_pull_out
);
   initial clock_pull_out = 1'b0;
   // one readout, low phase of lo cycles
   task automatic read_word(input int lo, output logic [9:0] w);
      @(posedge clk_in);
      clock_pull_out <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         repeat (lo) @(posedge clk_in);
         w[i] = data_pin_in;
         clock_pull_out <= 1'b0;
         repeat (4) @(posedge clk_in);
         clock_pull_out <= 1'b1;
      end
      repeat (lo) @(posedge clk_in);
      clock_pull_out <= 1'b0;
      // let the flags settle before the next readout
      repeat (8) @(posedge clk_in);
   endtask
endmodule

// ### tb/fcr_fault_capture_serial_readout_tb_top.sv
`timescale 1ns/1ps
module fcr_fault_capture_serial_readout_tb_top;
   logic clk_in, rst_n_in, regulator_uv_in, logic_uv_in, overtemp_in, latch_en, snap_ready_in;
   logic [5:0] fet_on_in, vds_over_in;
   logic [2:0] boot_uv_in;
   logic [9:0] w;
   int n_mismatch, total_checks, n;
   wire d_oe, c_oe, d_out, c_out, pull, snap_valid, dis;
   wire [9:0] cap, snap;
   // open-drain pins with pull-ups
   wire data_pin = d_oe ? 1'b1 : d_out;
   wire clock_pin = !c_oe ? c_out : !pull;
   fcr_fault_capture_serial_readout fcr_fault_capture_serial_readout_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .fet_on_in(fet_on_in), .vds_over_in(vds_over_in),
      .regulator_uv_in(regulator_uv_in), .boot_uv_in(boot_uv_in), .logic_uv_in(logic_uv_in),
      .overtemp_in(overtemp_in), .short_latch_enable_in(latch_en), .fault_flag_data_in(data_pin),
      .fault_flag_data_out(d_out), .fault_flag_data_oe_n_out(d_oe),
      .fault_flag_clock_in(clock_pin), .fault_flag_clock_out(c_out),
      .fault_flag_clock_oe_n_out(c_oe), .outputs_disable_out(dis), .fault_capture_out(cap),
      .snap_valid_out(snap_valid), .snap_ready_in(snap_ready_in), .snap_data_out(snap));
   fcr_ctrl_model fcr_ctrl_model_inst (.clk_in(clk_in), .data_pin_in(data_pin),
      .clock_pull_out(pull));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // verdict and end of run
   task automatic conclude();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait for the clock flag release
   task automatic wait_fault();
      int k;
      k = 0;
      while (c_oe !== 1'b1 && k < 200) begin
         @(posedge clk_in);
         k++;
      end
      if (c_oe !== 1'b1) begin
         chk("fault_wait", 10'h001, {9'h000, c_oe});
         conclude();
      end
   endtask
   task automatic rd(input int lo, input logic [9:0] exp);
      fcr_ctrl_model_inst.read_word(lo, w);
      chk("readout", exp, w);
   endtask
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      {rst_n_in, regulator_uv_in, logic_uv_in, overtemp_in, latch_en, snap_ready_in} = '0;
      {fet_on_in, vds_over_in, boot_uv_in} = '0;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      vds_over_in <= 6'h3f;
      repeat (10) @(posedge clk_in);
      chk("idle", 10'h000, {cap[9:2], d_oe, c_oe});
      fet_on_in <= 6'h02;
      repeat (20) @(posedge clk_in);
      chk("blank", 10'h000, cap);
      repeat (60) @(posedge clk_in);
      chk("latch_off", 10'h002, cap);
      chk("dis_latch_off", 10'h000, {9'h000, dis});
      fet_on_in <= 6'h20;
      latch_en <= 1'b1;
      repeat (80) @(posedge clk_in);
      {fet_on_in, vds_over_in} <= '0;
      wait_fault();
      chk("accum", 10'h022, cap);
      chk("short", 10'h001, {8'h00, d_oe, c_oe});
      chk("dis_latched", 10'h001, {9'h000, dis});
      rd(6, 10'h022);
      repeat (3) @(posedge clk_in);
      chk("cleared", 10'h000, {cap[9:2], d_oe, c_oe});
      // undervoltage, persistence and snapshot buffer
      regulator_uv_in <= 1'b1;
      boot_uv_in <= 3'h4;
      repeat (10) @(posedge clk_in);
      boot_uv_in <= 3'h0;
      wait_fault();
      chk("uv", 10'h003, {8'h00, d_oe, c_oe});
      rd(12, 10'h240);
      repeat (8) @(posedge clk_in);
      chk("reshow", 10'h043, {cap[9:2], d_oe, c_oe});
      for (int i = 0; i < 15; i++) rd(6, 10'h040);
      regulator_uv_in <= 1'b0;
      snap_ready_in <= 1'b1;
      n = 0;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (snap_valid === 1'b1) begin
            chk("snap", n == 0 ? 10'h022 : n == 1 ? 10'h240 : 10'h040, snap);
            n++;
         end
      end
      chk("depth", 10'd16, n[9:0]);
      // logic undervoltage, overtemperature, stale bit
      logic_uv_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk("luv", 10'h003, {cap[9:2], d_oe, c_oe});
      logic_uv_in <= 1'b0;
      overtemp_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk("otemp", 10'h000, {cap[9:2], d_oe, c_oe});
      overtemp_in <= 1'b0;
      regulator_uv_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      regulator_uv_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk("stale", 10'h040, cap);
      rst_n_in <= 1'b0;
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      chk("rst", 10'h000, cap);
      conclude();
   end
endmodule
